// File: rtl/ddrct_pkg.sv
// package: register map, field layout and command codes of the command timing block
package ddrct_pkg;

  // ----------------------------------------------------------------
  // register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONFIG   = 8'h00;
  localparam logic [7:0] ADDR_TIMING1  = 8'h04;
  localparam logic [7:0] ADDR_TIMING2  = 8'h08;
  localparam logic [7:0] ADDR_STATUS   = 8'h0C;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int UNLOCK_BIT = 15;
  localparam int RFC_LSB = 25;
  localparam int RFC_W   = 7;
  localparam int RP_LSB  = 22;
  localparam int RP_W    = 3;
  localparam int RCD_LSB = 19;
  localparam int RCD_W   = 3;
  localparam int WR_LSB  = 16;
  localparam int WR_W    = 3;
  localparam int RAS_LSB = 11;
  localparam int RAS_W   = 5;
  localparam int RC_LSB  = 6;
  localparam int RC_W    = 5;
  localparam int RRD_LSB = 3;
  localparam int RRD_W   = 3;
  localparam int WTR_LSB = 0;
  localparam int WTR_W   = 2;

  // ----------------------------------------------------------------
  // reset values and masks
  // ----------------------------------------------------------------
  localparam logic [31:0] CONFIG_RST   = 32'h0000_0000;
  localparam logic [31:0] CONFIG_MASK  = 32'h0000_8000;
  localparam logic [31:0] TIMING1_RST  = 32'h0000_0000;
  localparam logic [31:0] TIMING1_MASK = 32'hFFFF_FFFB;
  localparam logic [31:0] TIMING2_RST  = 32'h4532_A722;
  localparam logic [31:0] TIMING2_MASK = 32'h7FFF_FFFF;

  // ----------------------------------------------------------------
  // commands and carriers
  // ----------------------------------------------------------------
  localparam int CNT_W  = 8;
  localparam int BANKS  = 8;
  localparam logic [2:0] CMD_REFRESH   = 3'h0;
  localparam logic [2:0] CMD_MODE_LOAD = 3'h1;
  localparam logic [2:0] CMD_PRECHARGE = 3'h2;
  localparam logic [2:0] CMD_ACTIVATE  = 3'h3;
  localparam logic [2:0] CMD_READ      = 3'h4;
  localparam logic [2:0] CMD_WRITE     = 3'h5;

  typedef struct packed {
    logic       valid;
    logic [2:0] code;
    logic [2:0] bank;
  } ddrct_cmd_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } ddrct_apb_req_s;

endpackage : ddrct_pkg

// File: rtl/ddrct_timing.sv
// module: command spacing timing registers and gap counters on the memory clock
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - first timing register accepts writes only while the unlock bit is one.
// - second timing register accepts writes only while the unlock bit is one.
// - refresh gap plus one cycles after refresh or mode load before refresh/activate.
// - precharge gap plus one cycles after precharge before refresh or activate.
// - activate-to-access gap plus one cycles between activate and read or write.
// - write recovery gap plus one cycles after last write before precharge.
// - a write changing the write recovery field starts memory initialization.
// - row stays open activate-to-precharge gap plus one cycles before precharge.
// - activates to one bank are spaced by activate cycle gap plus one.
// - activates to different banks are spaced by bank gap plus one.
// - write-to-read gap plus one cycles after last write before a read.
module ddrct_timing (
  // clock and reset
  input  wire  logic                 pclk,
  input  wire  logic                 presetn,
  // apb slave
  input  wire  ddrct_pkg::ddrct_apb_req_s apb,
  output var   logic                 pready,
  output var   logic [31:0]          prdata,
  output var   logic                 pslverr,
  // memory clock from the link
  input  wire  logic                 mem_clk,
  // command request and issue
  input  wire  ddrct_pkg::ddrct_cmd_s cmd_req,
  output var   logic                 cmd_issue,
  output var   logic [2:0]           cmd_code,
  output var   logic [2:0]           cmd_bank,
  // initialization restart
  output var   logic                 init_start
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef logic [ddrct_pkg::CNT_W-1:0] ddrct_cnt_t;

  typedef struct packed {
    logic [1:0]   clk_sync;
    logic         clk_prev;
    logic [31:0]  config_reg;
    logic [31:0]  timing_one;
    logic [31:0]  timing_two;
    ddrct_cnt_t   rfc;
    ddrct_cnt_t   rp;
    ddrct_cnt_t   rcd;
    ddrct_cnt_t   wr;
    ddrct_cnt_t   ras;
    ddrct_cnt_t   rrd;
    ddrct_cnt_t   wtr;
    ddrct_cnt_t [ddrct_pkg::BANKS-1:0] rc;
    logic [2:0]   last_bank;
    logic         issue;
    logic [2:0]   code;
    logic [2:0]   bank;
    logic         init;
    logic         pready;
    logic [31:0]  prdata;
    logic         pslverr;
  } ddrct_state_s;

  ddrct_state_s st;
  ddrct_state_s next_st;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // field is gap minus one and the issuing tick counts, so the bare field is loaded
  function automatic ddrct_cnt_t gap(input logic [31:0] r, input int lsb, input int w);
    logic [31:0] f;
    f = (r >> lsb) & ((32'h1 << w) - 32'h1);
    return ddrct_cnt_t'(f);
  endfunction : gap

  function automatic ddrct_cnt_t dec(input ddrct_cnt_t c, input logic tick);
    return (tick && c != '0) ? ddrct_cnt_t'(c - 1'b1) : c;
  endfunction : dec

  function automatic logic [31:0] read_map(input logic [7:0] a, input ddrct_state_s s);
    case (a)
      ddrct_pkg::ADDR_CONFIG:  return s.config_reg;
      ddrct_pkg::ADDR_TIMING1: return s.timing_one;
      ddrct_pkg::ADDR_TIMING2: return s.timing_two;
      ddrct_pkg::ADDR_STATUS:  return {25'h0, s.wtr != '0, s.rrd != '0, s.ras != '0,
                                       s.wr != '0, s.rcd != '0, s.rp != '0, s.rfc != '0};
      default:                 return 32'h0000_0000;
    endcase
  endfunction : read_map

  function automatic logic mapped(input logic [7:0] a);
    return a == ddrct_pkg::ADDR_CONFIG || a == ddrct_pkg::ADDR_TIMING1 ||
           a == ddrct_pkg::ADDR_TIMING2 || a == ddrct_pkg::ADDR_STATUS;
  endfunction : mapped

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic tick;
  logic wr_en;
  logic unlocked;
  logic allow;
  logic [31:0] wdat;

  always_comb begin
    next_st  = st;
    // memory clock edge seen through the two-flop synchroniser
    next_st.clk_sync = {st.clk_sync[0], mem_clk};
    next_st.clk_prev = st.clk_sync[1];
    tick     = st.clk_sync[1] && !st.clk_prev;
    wr_en    = apb.psel && apb.penable && st.pready && apb.pwrite;
    unlocked = st.config_reg[ddrct_pkg::UNLOCK_BIT];
    wdat     = apb.pwdata;

    // apb: no wait state, answer registered on the setup cycle
    next_st.pready  = apb.psel && !apb.penable && !st.pready;
    next_st.prdata  = read_map(apb.paddr, st);
    next_st.pslverr = apb.psel && !apb.penable && !mapped(apb.paddr);
    next_st.init    = 1'b0;

    if (wr_en && apb.paddr == ddrct_pkg::ADDR_CONFIG) begin
      next_st.config_reg = wdat & ddrct_pkg::CONFIG_MASK;
    end
    if (wr_en && apb.paddr == ddrct_pkg::ADDR_TIMING1 && unlocked) begin
      next_st.timing_one = wdat & ddrct_pkg::TIMING1_MASK;
      // restart only when the recovery field really changes
      next_st.init = wdat[ddrct_pkg::WR_LSB +: ddrct_pkg::WR_W] !=
                     st.timing_one[ddrct_pkg::WR_LSB +: ddrct_pkg::WR_W];
    end
    if (wr_en && apb.paddr == ddrct_pkg::ADDR_TIMING2 && unlocked) begin
      next_st.timing_two = wdat & ddrct_pkg::TIMING2_MASK;
    end

    // gap counters run on the memory clock tick
    next_st.rfc = dec(st.rfc, tick);
    next_st.rp  = dec(st.rp, tick);
    next_st.rcd = dec(st.rcd, tick);
    next_st.wr  = dec(st.wr, tick);
    next_st.ras = dec(st.ras, tick);
    next_st.rrd = dec(st.rrd, tick);
    next_st.wtr = dec(st.wtr, tick);
    for (int b = 0; b < ddrct_pkg::BANKS; b++) begin
      next_st.rc[b] = dec(st.rc[b], tick);
    end

    // command gating
    case (cmd_req.code)
      ddrct_pkg::CMD_REFRESH,
      ddrct_pkg::CMD_MODE_LOAD: allow = st.rfc == '0 && st.rp == '0;
      ddrct_pkg::CMD_ACTIVATE:  allow = st.rfc == '0 && st.rp == '0 &&
                                        st.rc[cmd_req.bank] == '0 &&
                                        (st.rrd == '0 || cmd_req.bank == st.last_bank);
      ddrct_pkg::CMD_PRECHARGE: allow = st.wr == '0 && st.ras == '0;
      ddrct_pkg::CMD_READ:      allow = st.rcd == '0 && st.wtr == '0;
      ddrct_pkg::CMD_WRITE:     allow = st.rcd == '0;
      default:                  allow = 1'b0;
    endcase

    // commands go out only on a memory clock tick
    next_st.issue = tick && cmd_req.valid && allow;
    next_st.code  = cmd_req.code;
    next_st.bank  = cmd_req.bank;
    if (next_st.issue) begin
      case (cmd_req.code)
        ddrct_pkg::CMD_REFRESH,
        ddrct_pkg::CMD_MODE_LOAD: begin
          next_st.rfc = gap(st.timing_one, ddrct_pkg::RFC_LSB, ddrct_pkg::RFC_W);
        end
        ddrct_pkg::CMD_PRECHARGE: begin
          next_st.rp = gap(st.timing_one, ddrct_pkg::RP_LSB, ddrct_pkg::RP_W);
        end
        ddrct_pkg::CMD_ACTIVATE: begin
          next_st.rcd = gap(st.timing_one, ddrct_pkg::RCD_LSB, ddrct_pkg::RCD_W);
          next_st.ras = gap(st.timing_one, ddrct_pkg::RAS_LSB, ddrct_pkg::RAS_W);
          next_st.rrd = gap(st.timing_one, ddrct_pkg::RRD_LSB, ddrct_pkg::RRD_W);
          next_st.rc[cmd_req.bank] =
            gap(st.timing_one, ddrct_pkg::RC_LSB, ddrct_pkg::RC_W);
          next_st.last_bank = cmd_req.bank;
        end
        ddrct_pkg::CMD_WRITE: begin
          // the write command stands in for its last data beat
          next_st.wr  = gap(st.timing_one, ddrct_pkg::WR_LSB, ddrct_pkg::WR_W);
          next_st.wtr = gap(st.timing_one, ddrct_pkg::WTR_LSB, ddrct_pkg::WTR_W);
        end
        default: begin
          next_st.last_bank = st.last_bank;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st            <= '0;
      st.config_reg <= ddrct_pkg::CONFIG_RST;
      st.timing_one <= ddrct_pkg::TIMING1_RST;
      st.timing_two <= ddrct_pkg::TIMING2_RST;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign pready     = st.pready;
  assign prdata     = st.prdata;
  assign pslverr    = st.pslverr;
  assign cmd_issue  = st.issue;
  assign cmd_code   = st.code;
  assign cmd_bank   = st.bank;
  assign init_start = st.init;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_lock_one;
    @(posedge pclk) disable iff (!presetn)
    (apb.psel && apb.penable && st.pready && apb.pwrite &&
     apb.paddr == ddrct_pkg::ADDR_TIMING1 && !st.config_reg[ddrct_pkg::UNLOCK_BIT])
    |=> $stable(st.timing_one);
  endproperty
  a_lock_one: assert property (p_lock_one) else $error("locked timing one changed");

  property p_lock_two;
    @(posedge pclk) disable iff (!presetn)
    (apb.psel && apb.penable && st.pready && apb.pwrite &&
     apb.paddr == ddrct_pkg::ADDR_TIMING2 && !st.config_reg[ddrct_pkg::UNLOCK_BIT])
    |=> $stable(st.timing_two);
  endproperty
  a_lock_two: assert property (p_lock_two) else $error("locked timing two changed");

  property p_refresh_gap;
    @(posedge pclk) disable iff (!presetn)
    st.issue && (st.code == ddrct_pkg::CMD_ACTIVATE || st.code == ddrct_pkg::CMD_REFRESH)
    |-> $past(st.rfc) == '0;
  endproperty
  a_refresh_gap: assert property (p_refresh_gap) else $error("refresh gap broken");

  property p_precharge_gap;
    @(posedge pclk) disable iff (!presetn)
    st.issue && st.code == ddrct_pkg::CMD_PRECHARGE
    |-> st.rp == ddrct_cnt_t'(st.timing_one[ddrct_pkg::RP_LSB +: ddrct_pkg::RP_W]);
  endproperty
  a_precharge_gap: assert property (p_precharge_gap) else $error("precharge gap not loaded");

  property p_access_gap;
    @(posedge pclk) disable iff (!presetn)
    st.issue && (st.code == ddrct_pkg::CMD_READ || st.code == ddrct_pkg::CMD_WRITE)
    |-> $past(st.rcd) == '0;
  endproperty
  a_access_gap: assert property (p_access_gap) else $error("activate to access gap broken");

  property p_recovery_gap;
    @(posedge pclk) disable iff (!presetn)
    st.issue && st.code == ddrct_pkg::CMD_PRECHARGE |-> $past(st.wr) == '0 && $past(st.ras) == '0;
  endproperty
  a_recovery_gap: assert property (p_recovery_gap) else $error("precharge too early");

  property p_init_restart;
    @(posedge pclk) disable iff (!presetn)
    $changed(st.timing_one[ddrct_pkg::WR_LSB +: ddrct_pkg::WR_W]) |-> st.init;
  endproperty
  a_init_restart: assert property (p_init_restart) else $error("no init on recovery change");

  property p_bank_gap;
    @(posedge pclk) disable iff (!presetn)
    tick && cmd_req.valid && cmd_req.code == ddrct_pkg::CMD_ACTIVATE &&
    st.rc[cmd_req.bank] != '0 |=> !st.issue;
  endproperty
  a_bank_gap: assert property (p_bank_gap) else $error("same bank activate too early");

  property p_read_gap;
    @(posedge pclk) disable iff (!presetn)
    st.issue && st.code == ddrct_pkg::CMD_READ |-> $past(st.wtr) == '0;
  endproperty
  a_read_gap: assert property (p_read_gap) else $error("write to read gap broken");

  property p_tick_only;
    @(posedge pclk) disable iff (!presetn)
    st.rcd != '0 && !(st.clk_sync[1] && !st.clk_prev) && !st.issue |=> st.rcd == $past(st.rcd);
  endproperty
  a_tick_only: assert property (p_tick_only) else $error("counter moved without tick");

  property p_rp_block;
    @(posedge pclk) disable iff (!presetn)
    st.issue && (st.code == ddrct_pkg::CMD_ACTIVATE || st.code == ddrct_pkg::CMD_REFRESH)
    |-> $past(st.rp) == '0;
  endproperty
  a_rp_block: assert property (p_rp_block) else $error("precharge gap short");

  property p_row_open;
    @(posedge pclk) disable iff (!presetn)
    st.issue && st.code == ddrct_pkg::CMD_PRECHARGE |-> $past(st.ras) == '0;
  endproperty
  a_row_open: assert property (p_row_open) else $error("row closed too early");

  property p_rrd_gap;
    @(posedge pclk) disable iff (!presetn)
    st.issue && st.code == ddrct_pkg::CMD_ACTIVATE && st.bank != $past(st.last_bank)
    |-> $past(st.rrd) == '0;
  endproperty
  a_rrd_gap: assert property (p_rrd_gap) else $error("bank to bank gap broken");

  property p_init_cause;
    @(posedge pclk) disable iff (!presetn)
    st.init |-> $changed(st.timing_one[ddrct_pkg::WR_LSB +: ddrct_pkg::WR_W]);
  endproperty
  a_init_cause: assert property (p_init_cause) else $error("init without field change");

  property p_init_pulse;
    @(posedge pclk) disable iff (!presetn)
    st.init |=> !st.init;
  endproperty
  a_init_pulse: assert property (p_init_pulse) else $error("init pulse too long");

  property p_write_lands;
    @(posedge pclk) disable iff (!presetn)
    wr_en && apb.paddr == ddrct_pkg::ADDR_TIMING1 && unlocked
    |=> st.timing_one == ($past(apb.pwdata) & ddrct_pkg::TIMING1_MASK);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("unlocked write lost");

  property p_issue_tick;
    @(posedge pclk) disable iff (!presetn)
    st.issue |-> $past(tick);
  endproperty
  a_issue_tick: assert property (p_issue_tick) else $error("command off the tick");

  property p_issue_pulse;
    @(posedge pclk) disable iff (!presetn)
    st.issue |=> !st.issue;
  endproperty
  a_issue_pulse: assert property (p_issue_pulse) else $error("issue pulse too long");

  property p_ready_pulse;
    @(posedge pclk) disable iff (!presetn)
    st.pready |=> !st.pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

endmodule : ddrct_timing
`default_nettype wire

// File: bench/ddrct_mem_model.sv
// memory side model: free running memory clock, tick count, command code check
`timescale 1ns/1ps
`default_nettype none
module ddrct_mem_model (
  // controller side
  input  wire logic       pclk,
  input  wire logic       cmd_issue,
  input  wire logic [2:0] cmd_code,
  // memory clock and counts
  output var  logic       mem_clk,
  output var  int         ticks,
  output var  int         bad_cmds
);
  // odd start offset keeps the memory clock out of phase with pclk
  initial begin
    mem_clk = 1'b0;
    #37;
    forever #400 mem_clk = ~mem_clk;
  end
  always @(posedge mem_clk) ticks++;
  // only the six documented codes may reach the memory
  always @(posedge pclk) if (cmd_issue === 1'b1 && cmd_code > 3'h5) bad_cmds++;
endmodule : ddrct_mem_model
`default_nettype wire

// File: bench/tb_ddrct_timing.sv
// self-checking bench of the command timing block
`timescale 1ns/1ps
`default_nettype none
module tb_ddrct_timing;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                      pclk, presetn, pready, pslverr, err;
  logic                      mem_clk, cmd_issue, init_start;
  logic [31:0]               prdata, rd;
  logic [2:0]                cmd_code, cmd_bank;
  ddrct_pkg::ddrct_apb_req_s apb;
  ddrct_pkg::ddrct_cmd_s     cmd_req;
  int                        ticks, bad_cmds, n_init, n_errors, checked;
  // rfc 5, rp 3, rcd 2, wr 4, ras 6, rc 7, rrd 1, wtr 2, reserved bit 2 set
  // ras not below rcd bank spacing as for eight banks
  localparam logic [31:0] T1 = 32'h0AD4_31CE;

  ddrct_timing u_ddrct_timing (.pclk(pclk), .presetn(presetn), .apb(apb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .mem_clk(mem_clk), .cmd_req(cmd_req),
    .cmd_issue(cmd_issue), .cmd_code(cmd_code), .cmd_bank(cmd_bank), .init_start(init_start));
  ddrct_mem_model u_ddrct_mem_model (.pclk(pclk), .cmd_issue(cmd_issue), .cmd_code(cmd_code),
    .mem_clk(mem_clk), .ticks(ticks), .bad_cmds(bad_cmds));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) if (init_start === 1'b1) n_init++;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    apb <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    apb.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (pready !== 1'b1) chk("pready", 32'h1, 32'h0);
    apb <= '0;
  endtask : apb_xfer

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb_xfer(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask : rd_chk

  // holds the request until the issue pulse, then drops it on that edge
  task automatic issue(input logic [2:0] c, input logic [2:0] b, output int t);
    int n;
    n = 0;
    @(posedge pclk);
    cmd_req <= '{1'b1, c, b};
    do begin
      @(posedge pclk);
      n++;
    end while (cmd_issue !== 1'b1 && n < 400);
    t = ticks;
    cmd_req <= '0;
    chk("cmd_issue", 32'h1, {31'h0, cmd_issue});
    chk("cmd_code", {29'h0, c}, {29'h0, cmd_code});
    chk("cmd_bank", {29'h0, b}, {29'h0, cmd_bank});
  endtask : issue

  // idle first so only the gap under test is still running
  task automatic gap(input logic [2:0] c1, b1, c2, b2, input int exp);
    int t1, t2;
    repeat (120) @(posedge pclk);
    issue(c1, b1, t1);
    issue(c2, b2, t2);
    chk("tick gap", 32'(exp), 32'(t2 - t1));
  endtask : gap

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    int n0;
    n0 = n_init;
    rd_chk("config", ddrct_pkg::ADDR_CONFIG, ddrct_pkg::CONFIG_RST);
    rd_chk("status", ddrct_pkg::ADDR_STATUS, 32'h0);
    apb_xfer(1'b0, 8'h10, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    apb_xfer(1'b1, ddrct_pkg::ADDR_TIMING1, T1);
    rd_chk("locked one", ddrct_pkg::ADDR_TIMING1, ddrct_pkg::TIMING1_RST);
    apb_xfer(1'b1, ddrct_pkg::ADDR_TIMING2, 32'h0);
    rd_chk("locked two", ddrct_pkg::ADDR_TIMING2, ddrct_pkg::TIMING2_RST);
    chk("init locked", 32'h0, 32'(n_init - n0));
    apb_xfer(1'b1, ddrct_pkg::ADDR_CONFIG, 32'hFFFF_FFFF);
    rd_chk("config", ddrct_pkg::ADDR_CONFIG, ddrct_pkg::CONFIG_MASK);
    apb_xfer(1'b1, ddrct_pkg::ADDR_TIMING1, T1);
    rd_chk("timing one", ddrct_pkg::ADDR_TIMING1, T1 & ddrct_pkg::TIMING1_MASK);
    chk("init change", 32'h1, 32'(n_init - n0));
    apb_xfer(1'b1, ddrct_pkg::ADDR_TIMING1, T1 ^ 32'h0000_0001);
    apb_xfer(1'b1, ddrct_pkg::ADDR_TIMING1, T1 ^ 32'h0001_0000);
    apb_xfer(1'b1, ddrct_pkg::ADDR_TIMING1, T1);
    rd_chk("timing one", ddrct_pkg::ADDR_TIMING1, T1 & ddrct_pkg::TIMING1_MASK);
    chk("init count", 32'h3, 32'(n_init - n0));
    apb_xfer(1'b1, ddrct_pkg::ADDR_TIMING2, 32'hFFFF_FFFF);
    rd_chk("timing two", ddrct_pkg::ADDR_TIMING2, ddrct_pkg::TIMING2_MASK);
    apb_xfer(1'b1, ddrct_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
    rd_chk("status ro", ddrct_pkg::ADDR_STATUS, 32'h0);
    $display("test registers done");
  endtask : t_regs

  task automatic t_gaps;
    int t;
    gap(ddrct_pkg::CMD_REFRESH, 3'h0, ddrct_pkg::CMD_REFRESH, 3'h0, 6);
    gap(ddrct_pkg::CMD_MODE_LOAD, 3'h0, ddrct_pkg::CMD_ACTIVATE, 3'h0, 6);
    gap(ddrct_pkg::CMD_PRECHARGE, 3'h0, ddrct_pkg::CMD_ACTIVATE, 3'h0, 4);
    gap(ddrct_pkg::CMD_PRECHARGE, 3'h0, ddrct_pkg::CMD_REFRESH, 3'h0, 4);
    gap(ddrct_pkg::CMD_ACTIVATE, 3'h0, ddrct_pkg::CMD_READ, 3'h0, 3);
    gap(ddrct_pkg::CMD_ACTIVATE, 3'h0, ddrct_pkg::CMD_WRITE, 3'h0, 3);
    gap(ddrct_pkg::CMD_WRITE, 3'h0, ddrct_pkg::CMD_PRECHARGE, 3'h0, 5);
    gap(ddrct_pkg::CMD_ACTIVATE, 3'h0, ddrct_pkg::CMD_PRECHARGE, 3'h0, 7);
    gap(ddrct_pkg::CMD_ACTIVATE, 3'h0, ddrct_pkg::CMD_ACTIVATE, 3'h0, 8);
    gap(ddrct_pkg::CMD_ACTIVATE, 3'h2, ddrct_pkg::CMD_ACTIVATE, 3'h7, 2);
    gap(ddrct_pkg::CMD_WRITE, 3'h0, ddrct_pkg::CMD_READ, 3'h0, 3);
    repeat (120) @(posedge pclk);
    issue(ddrct_pkg::CMD_REFRESH, 3'h0, t);
    rd_chk("status busy", ddrct_pkg::ADDR_STATUS, 32'h1);
    // an undefined code must never reach the memory
    cmd_req <= '{1'b1, 3'h6, 3'h0};
    repeat (40) @(posedge pclk);
    cmd_req <= '0;
    repeat (2) @(posedge pclk);
    chk("bad codes", 32'h0, 32'(bad_cmds));
    $display("test gaps done");
  endtask : t_gaps

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  initial begin
    presetn = 1'b0;
    apb = '0;
    cmd_req = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_gaps();
    wrap_up();
  end

  // the whole run needs well under half of this span
  initial begin
    #1_000_000;
    n_errors++;
    $display("ERROR watchdog expected end seen hang");
    wrap_up();
  end
endmodule : tb_ddrct_timing
`default_nettype wire
